// ===== verilog/tlb_flush_pkg.sv
package tlb_flush_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int ENTRIES = 8;
  localparam int IDX_W = 3;
  localparam int SPACE_W = 8;
  localparam int VPN_W = 20;
  localparam int PPN_W = 20;
  localparam int PAGE_SHIFT = 12;

  // ----------------------------------------
  // Flush command encodings
  // ----------------------------------------
  localparam logic [7:0] CMD_NONE = 8'h00;
  localparam logic [7:0] CMD_ALL = 8'h01;
  localparam logic [7:0] CMD_SPACE = 8'h03;
  localparam logic [7:0] CMD_SPACE_NONGLOBAL = 8'h07;

  // Per-space flush encodings built in
  localparam logic PER_SPACE_FLUSH_SUPPORT = 1'b1;
  localparam logic [SPACE_W-1:0] HOST_SPACE = 8'h00;

  // ----------------------------------------
  // Register map (byte offsets) and fields
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CAP = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_FLUSH_COUNT = 8'h0C;
  localparam int CTRL_VIRT_EN = 0;
  localparam logic CTRL_RESET = 1'b0;
  localparam int CAP_PER_SPACE = 0;
  localparam int CAP_BASE_CMDS = 1;
  localparam int STATUS_SPACE_LSB = 0;
  localparam int STATUS_IN_GUEST = 8;
  localparam int STATUS_CMD_RESERVED = 9;
  localparam int STATUS_LAST_CMD_LSB = 16;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic global_page;
    logic [SPACE_W-1:0] space;
    logic [VPN_W-1:0] vpn;
    logic [PPN_W-1:0] ppn;
  } tlb_entry_t;

  typedef struct packed {
    logic cr3_load;
    logic task_cr3;
    logic pg_toggle;
    logic cr4_paging;
    logic cr4_load;
    logic intercept;
  } arch_evt_t;

  typedef struct packed {
    logic smi_entry;
    logic sm_resume;
    logic memory_type_range_regs;
    logic io_range_regs;
    logic xlat_sysreg;
  } sys_evt_t;

  typedef enum logic [1:0] {
    MODE_HOST = 2'b00,
    MODE_GUEST = 2'b01
  } mode_t;

endpackage

// ===== verilog/asid_tagged_tlb_flush_control.sv
`timescale 1ns/10ps
// Functional notes
// [RULE1] Every entry carries an address space tag
// [RULE2] Guest entry/exit register loads never flush
// [RULE3] Global entries match own space when enabled
// [RULE4] CR3 load non-global, CR4 load all
// [RULE5] Intercepted flushing action exits, no flush
// [RULE6] Command byte 00/01/03/07, others reserved
// [RULE7] 00/01 always; per-space ones reported
// [RULE8] Command 01 flushes every space
// [RULE9] Guest entry never modifies the command
// [RULE10] Paging events flush current space only
// [RULE11] Host mode uses space zero
// [RULE12] System events flush every space
// [RULE13] Page invalidate by address and space
// [RULE14] Hypervisor flushes after paging control edits
// [RULE15] Hypervisor uses 03/01 after table edits
// [RULE16] Fresh space not reused before full flush
// [RULE17] Entry flush done before first lookup
module asid_tagged_tlb_flush_control
  import tlb_flush_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Guest entry and exit
  input wire logic guest_entry_i,
  input wire logic [7:0] tlb_flush_command_i,
  input wire logic [SPACE_W-1:0] guest_space_i,
  output logic guest_exit_o,
  // Architectural and system events
  input wire arch_evt_t arch_evt_i,
  input wire sys_evt_t sys_evt_i,
  // Page invalidate
  input wire logic inv_page_i,
  input wire logic [63:0] inv_rax_i,
  input wire logic [31:0] inv_ecx_i,
  // Fill
  input wire logic fill_i,
  input wire logic [VPN_W-1:0] fill_vpn_i,
  input wire logic [PPN_W-1:0] fill_ppn_i,
  input wire logic fill_global_i,
  // Lookup
  input wire logic lookup_i,
  input wire logic [VPN_W-1:0] lookup_vpn_i,
  output logic lookup_done_o,
  output logic lookup_hit_o,
  output logic [PPN_W-1:0] lookup_ppn_o
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic entry_match(input tlb_entry_t e, input logic [VPN_W-1:0] vpn,
                                       input logic [SPACE_W-1:0] space, input logic virt_en);
    // Global only crosses spaces with the extension off
    entry_match = e.valid && (e.vpn == vpn) && ((e.space == space) || (e.global_page && !virt_en)); // [RULE3]
  endfunction

  function automatic logic space_kill(input tlb_entry_t e, input logic [SPACE_W-1:0] space,
                                      input logic keep_global);
    space_kill = (e.space == space) && !(keep_global && e.global_page);
  endfunction

  function automatic logic page_match(input tlb_entry_t e, input logic [VPN_W-1:0] vpn,
                                      input logic [SPACE_W-1:0] space);
    page_match = (e.vpn == vpn) && (e.space == space);
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  tlb_entry_t tlb [ENTRIES];
  logic [ENTRIES-1:0] valid;
  logic [IDX_W-1:0] fill_ptr;
  mode_t mode;
  logic [SPACE_W-1:0] cur_space;
  logic virt_en;
  logic cmd_reserved;
  logic [7:0] last_cmd;
  logic [31:0] flush_count;

  // ----------------------------------------
  // Event decode
  // ----------------------------------------
  wire in_guest = (mode == MODE_GUEST);
  wire arch_any = arch_evt_i.cr3_load | arch_evt_i.task_cr3 | arch_evt_i.pg_toggle |
                  arch_evt_i.cr4_paging | arch_evt_i.cr4_load;
  // Intercepted action exits instead of flushing
  wire take_exit = in_guest && arch_any && arch_evt_i.intercept && !guest_entry_i; // [RULE5]
  wire arch_flush = arch_any && !take_exit && !guest_entry_i;
  wire arch_all = arch_evt_i.pg_toggle | arch_evt_i.cr4_paging | arch_evt_i.cr4_load; // [RULE4]
  wire sys_any = |sys_evt_i; // [RULE12]
  wire cmd_is_all = guest_entry_i && (tlb_flush_command_i == CMD_ALL); // [RULE8]
  wire cmd_is_space = guest_entry_i && PER_SPACE_FLUSH_SUPPORT && (tlb_flush_command_i == CMD_SPACE);
  wire cmd_is_ng = guest_entry_i && PER_SPACE_FLUSH_SUPPORT && (tlb_flush_command_i == CMD_SPACE_NONGLOBAL);
  // Unsupported per-space codes fall into reserved
  wire cmd_known = (tlb_flush_command_i == CMD_NONE) || (tlb_flush_command_i == CMD_ALL) ||
                   (PER_SPACE_FLUSH_SUPPORT && ((tlb_flush_command_i == CMD_SPACE) ||
                   (tlb_flush_command_i == CMD_SPACE_NONGLOBAL))); // [RULE6] [RULE7]
  wire [VPN_W-1:0] inv_vpn = inv_rax_i[PAGE_SHIFT +: VPN_W]; // [RULE13]
  wire [SPACE_W-1:0] inv_space = inv_ecx_i[SPACE_W-1:0]; // [RULE13]
  // Fill is refused in the entry cycle; space is about to change
  wire fill_take = fill_i && !guest_entry_i;
  wire lookup_take = lookup_i && !guest_entry_i; // [RULE17]

  // Per-entry kill vector
  logic [ENTRIES-1:0] kill;
  always_comb begin
    for (int i = 0; i < ENTRIES; i++) begin
      kill[i] = sys_any || cmd_is_all; // [RULE8] [RULE12]
      if (cmd_is_space || cmd_is_ng) begin
        kill[i] = kill[i] || space_kill(tlb[i], guest_space_i, cmd_is_ng);
      end
      if (arch_flush) begin
        // Current space only, host included
        kill[i] = kill[i] || space_kill(tlb[i], cur_space, !arch_all); // [RULE4] [RULE10]
      end
      if (inv_page_i) begin
        kill[i] = kill[i] || (tlb[i].valid && page_match(tlb[i], inv_vpn, inv_space)); // [RULE13]
      end
    end
  end

  wire any_kill = |(kill & valid);

  // ----------------------------------------
  // Entry array
  // ----------------------------------------
  // Kills win over a fill to the same slot
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valid <= '0;
      fill_ptr <= '0;
    end else begin
      for (int i = 0; i < ENTRIES; i++) begin
        valid[i] <= (valid[i] || (fill_take && fill_ptr == IDX_W'(i))) && !kill[i];
      end
      if (fill_take) begin
        fill_ptr <= fill_ptr + IDX_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (fill_take) begin
      tlb[fill_ptr] <= '{valid: 1'b1, global_page: fill_global_i, space: cur_space,
                         vpn: fill_vpn_i, ppn: fill_ppn_i}; // [RULE1]
    end
  end

  // ----------------------------------------
  // Mode and current space
  // ----------------------------------------
  // Register loads on entry/exit only move the space tag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode <= MODE_HOST;
      cur_space <= HOST_SPACE;
      guest_exit_o <= 1'b0;
    end else begin
      guest_exit_o <= take_exit;
      if (guest_entry_i) begin
        mode <= MODE_GUEST;
        cur_space <= guest_space_i; // [RULE2]
      end else if (take_exit) begin
        mode <= MODE_HOST;
        cur_space <= HOST_SPACE; // [RULE11]
      end
    end
  end

  // Command byte is only sampled, never written back
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_cmd <= CMD_NONE;
      cmd_reserved <= 1'b0;
    end else if (guest_entry_i) begin
      last_cmd <= tlb_flush_command_i; // [RULE9]
      cmd_reserved <= !cmd_known; // [RULE6]
    end
  end

  // ----------------------------------------
  // Lookup
  // ----------------------------------------
  logic [ENTRIES-1:0] hit_vec;
  logic [PPN_W-1:0] hit_ppn;
  always_comb begin
    hit_ppn = '0;
    for (int i = 0; i < ENTRIES; i++) begin
      hit_vec[i] = valid[i] && entry_match(tlb[i], lookup_vpn_i, cur_space, virt_en); // [RULE1] [RULE3]
      if (hit_vec[i]) begin
        hit_ppn = tlb[i].ppn;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lookup_done_o <= 1'b0;
      lookup_hit_o <= 1'b0;
      lookup_ppn_o <= '0;
    end else begin
      lookup_done_o <= lookup_take; // [RULE17]
      lookup_hit_o <= lookup_take && (|hit_vec);
      lookup_ppn_o <= lookup_take ? hit_ppn : '0;
    end
  end

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Write commits on the edge that sees ack, while the master still holds
  wire wr_ctrl = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && (wb_adr_i == REG_CTRL) && wb_sel_i[0];
  logic [31:0] status_word;
  logic [31:0] cap_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[STATUS_SPACE_LSB +: SPACE_W] = cur_space;
    status_word[STATUS_IN_GUEST] = in_guest;
    status_word[STATUS_CMD_RESERVED] = cmd_reserved;
    status_word[STATUS_LAST_CMD_LSB +: 8] = last_cmd;
    cap_word = 32'h0000_0000;
    cap_word[CAP_PER_SPACE] = PER_SPACE_FLUSH_SUPPORT; // [RULE7]
    cap_word[CAP_BASE_CMDS] = 1'b1; // [RULE7]
  end
  wire [31:0] rd_word = (wb_adr_i == REG_CTRL) ? {31'h0, virt_en} :
                        (wb_adr_i == REG_CAP) ? cap_word :
                        (wb_adr_i == REG_STATUS) ? status_word :
                        (wb_adr_i == REG_FLUSH_COUNT) ? flush_count : 32'h0000_0000;

  // One wait state; unmapped reads zero, writes dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      virt_en <= CTRL_RESET;
      flush_count <= '0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= (wb_req && !wb_we_i) ? rd_word : 32'h0000_0000;
      if (wr_ctrl) begin
        virt_en <= wb_dat_i[CTRL_VIRT_EN];
      end
      if (any_kill) begin
        flush_count <= flush_count + 32'h0000_0001;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Helper vectors for the checks; free slots read as zero
  logic [ENTRIES-1:0] foreign_vec;
  logic [ENTRIES-1:0] global_vec;
  logic [ENTRIES-1:0] page_vec;
  always_comb begin
    for (int i = 0; i < ENTRIES; i++) begin
      foreign_vec[i] = valid[i] && (tlb[i].space != cur_space);
      global_vec[i] = valid[i] && tlb[i].global_page;
      page_vec[i] = valid[i] && page_match(tlb[i], inv_vpn, inv_space);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_ack_pulse;
    wb_req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("wishbone ack not a single pulse");

  property p_entry_space;
    guest_entry_i |=> in_guest && cur_space == $past(guest_space_i);
  endproperty
  a_entry_space: assert property (p_entry_space) else $error("guest space not taken"); // [RULE2]

  property p_exit_host;
    guest_exit_o |-> !in_guest && cur_space == HOST_SPACE;
  endproperty
  a_exit_host: assert property (p_exit_host) else $error("host space not zero"); // [RULE11]

  property p_exit_keeps;
    take_exit && !sys_any && !inv_page_i && !fill_take |=> guest_exit_o && valid == $past(valid);
  endproperty
  a_exit_keeps: assert property (p_exit_keeps) else $error("intercept flushed entries"); // [RULE5]

  property p_cmd_all;
    guest_entry_i && tlb_flush_command_i == CMD_ALL |=> valid == '0;
  endproperty
  a_cmd_all: assert property (p_cmd_all) else $error("flush all left entries"); // [RULE8]

  property p_sys_all;
    sys_any |=> valid == '0;
  endproperty
  a_sys_all: assert property (p_sys_all) else $error("system event left entries"); // [RULE12]

  property p_cmd_none;
    guest_entry_i && tlb_flush_command_i == CMD_NONE && !sys_any && !inv_page_i |=> valid == $past(valid);
  endproperty
  a_cmd_none: assert property (p_cmd_none) else $error("no-flush entry changed entries"); // [RULE2]

  property p_reserved;
    guest_entry_i && !cmd_known |=> cmd_reserved && last_cmd == $past(tlb_flush_command_i);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved command not flagged"); // [RULE6]

  property p_no_lookup_on_entry;
    guest_entry_i |=> !lookup_done_o;
  endproperty
  a_no_lookup_on_entry: assert property (p_no_lookup_on_entry) else $error("lookup in entry cycle"); // [RULE17]

  property p_other_space_kept;
    arch_flush && !sys_any && !inv_page_i |=> (valid & $past(foreign_vec)) == $past(foreign_vec);
  endproperty
  a_other_space_kept: assert property (p_other_space_kept) else $error("scoped flush hit another space"); // [RULE10]

  property p_cr3_keeps_global;
    arch_flush && !arch_all && !sys_any && !inv_page_i |=> (valid & $past(global_vec)) == $past(global_vec);
  endproperty
  a_cr3_keeps_global: assert property (p_cr3_keeps_global) else $error("cr3 load dropped a global entry"); // [RULE4]

  property p_global_own_space;
    lookup_take && virt_en |-> (hit_vec & foreign_vec) == '0;
  endproperty
  a_global_own_space: assert property (p_global_own_space) else $error("global entry crossed spaces"); // [RULE3]

  property p_inv_page_scope;
    inv_page_i && !sys_any && !arch_flush && !guest_entry_i && !fill_take |=>
      valid == ($past(valid) & ~$past(page_vec));
  endproperty
  a_inv_page_scope: assert property (p_inv_page_scope) else $error("page invalidate wrong scope"); // [RULE13]

  c_cmd_all: cover property (guest_entry_i && tlb_flush_command_i == CMD_ALL && valid != '0);
  c_cmd_space: cover property (cmd_is_space && any_kill);
  c_inv_page: cover property (inv_page_i && any_kill);
  c_intercept: cover property (take_exit ##1 guest_exit_o);

endmodule

// ===== tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import tlb_flush_pkg::*;
  // ------------------------------
  // Stimulus and design
  // ------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] rd;
  logic ack;
  logic ge = 1'b0;
  logic [7:0] cmd = 8'h00;
  logic [SPACE_W-1:0] gsp = 8'h00;
  logic gex;
  logic ex;
  arch_evt_t aev = '0;
  sys_evt_t sev = '0;
  logic inv = 1'b0;
  logic [63:0] rax = 64'h0;
  logic [31:0] ecx = 32'h0;
  logic fill = 1'b0;
  logic fglob = 1'b0;
  logic [VPN_W-1:0] fvpn = '0;
  logic [PPN_W-1:0] fppn = '0;
  logic look = 1'b0;
  logic [VPN_W-1:0] lvpn = '0;
  logic done;
  logic hit;
  logic [PPN_W-1:0] lppn;
  logic [VPN_W-1:0] va, vb, vc;
  logic [PPN_W-1:0] pa, pb, pc;
  logic [SPACE_W-1:0] sp;
  int err_total = 0;
  int n_checks = 0;
  int cyc_n = 0;

  always #2.5 clk_i = ~clk_i;

  asid_tagged_tlb_flush_control u_asid_tagged_tlb_flush_control (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rd), .wb_ack_o(ack), .guest_entry_i(ge),
    .tlb_flush_command_i(cmd), .guest_space_i(gsp), .guest_exit_o(gex), .arch_evt_i(aev),
    .sys_evt_i(sev), .inv_page_i(inv), .inv_rax_i(rax), .inv_ecx_i(ecx), .fill_i(fill),
    .fill_vpn_i(fvpn), .fill_ppn_i(fppn), .fill_global_i(fglob), .lookup_i(look),
    .lookup_vpn_i(lvpn), .lookup_done_o(done), .lookup_hit_o(hit), .lookup_ppn_o(lppn));

  // ------------------------------
  // Checking and closing
  // ------------------------------
  task automatic wrap_up();
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Entry survives a guest entry command: 01/03 kill it, 07 spares globals
  function automatic logic keeps(input logic [7:0] c, input logic g);
    keeps = (c != CMD_ALL) && (c != CMD_SPACE) && ((c != CMD_SPACE_NONGLOBAL) || g);
  endfunction

  // Hang guard, the whole run needs a few hundred cycles
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      err_total++;
      wrap_up();
    end
  end

  // ------------------------------
  // Bus and pulse drivers
  // ------------------------------
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rd;
    cyc <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 4'hF, 32'h0, q);
    chk(q, e);
  endtask

  task automatic rst();
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  task automatic fl(input logic [VPN_W-1:0] v, input logic [PPN_W-1:0] p, input logic g);
    @(posedge clk_i);
    fill <= 1'b1;
    fvpn <= v;
    fppn <= p;
    fglob <= g;
    @(posedge clk_i);
    fill <= 1'b0;
  endtask

  task automatic enter(input logic [7:0] c, input logic [SPACE_W-1:0] s);
    @(posedge clk_i);
    ge <= 1'b1;
    cmd <= c;
    gsp <= s;
    @(posedge clk_i);
    ge <= 1'b0;
  endtask

  // One-cycle event pulse; upper operand bits are noise the block must ignore
  task automatic ev(input arch_evt_t a, input sys_evt_t s, input logic i, input logic [VPN_W-1:0] v,
                    input logic [SPACE_W-1:0] ss);
    @(posedge clk_i);
    aev <= a;
    sev <= s;
    inv <= i;
    rax <= {32'($urandom), v, 12'($urandom)};
    ecx <= {24'($urandom), ss};
    @(posedge clk_i);
    aev <= '0;
    sev <= '0;
    inv <= 1'b0;
    #1;
    ex = gex;
  endtask

  task automatic lk(input logic [VPN_W-1:0] v, input logic h, input logic [PPN_W-1:0] p);
    @(posedge clk_i);
    look <= 1'b1;
    lvpn <= v;
    @(posedge clk_i);
    look <= 1'b0;
    #1;
    chk(32'({done, hit, lppn}), 32'({1'b1, h, p & {PPN_W{h}}}));
  endtask

  task automatic rnd();
    va = VPN_W'($urandom);
    vb = va + 20'h00001;
    vc = va + 20'h00002;
    pa = PPN_W'($urandom);
    pb = PPN_W'($urandom);
    pc = PPN_W'($urandom);
    sp = SPACE_W'($urandom_range(254, 1));
  endtask

  initial begin
    logic [7:0] cmds [5];
    logic [7:0] c;
    logic [31:0] q;
    void'($urandom(67025));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(REG_CAP, {30'h0, 1'b1, PER_SPACE_FLUSH_SUPPORT});
    rdchk(REG_CTRL, 32'h0);
    rdchk(REG_STATUS, 32'h0);
    rdchk(8'h10, 32'h0);
    rdchk(REG_FLUSH_COUNT, 32'h0);
    // Every command code, then one reserved code
    cmds = '{CMD_NONE, CMD_ALL, CMD_SPACE, CMD_SPACE_NONGLOBAL, 8'h00};
    for (int i = 0; i < 5; i++) begin
      rnd();
      c = (i < 4) ? cmds[i] : {5'h1F, 3'($urandom)};
      rst();
      fl(va, pa, 1'b0);
      enter(CMD_NONE, sp);
      fl(vb, pb, 1'b0);
      fl(vc, pc, 1'b1);
      ev(6'h03, '0, 1'b0, va, sp);
      chk(32'(ex), 32'h1);
      rdchk(REG_STATUS, 32'h0);
      lk(va, 1'b1, pa);
      enter(c, sp);
      lk(vb, keeps(c, 1'b0), pb);
      lk(vc, keeps(c, 1'b1), pc);
      rdchk(REG_STATUS, {8'h00, c, 6'h00, 1'(i == 4), 1'b1, sp});
    end
    // Paging events, three in guest mode then two in host mode
    rnd();
    rst();
    // Lane 0 off: the enable write must be dropped
    wb(1'b1, REG_CTRL, 4'hE, 32'h1, q);
    rdchk(REG_CTRL, 32'h0);
    wb(1'b1, REG_CTRL, 4'h1, 32'h1, q);
    rdchk(REG_CTRL, 32'h1);
    fl(va, pa, 1'b0);
    enter(CMD_NONE, sp);
    fl(vb, pb, 1'b0);
    fl(vc, pc, 1'b1);
    for (int k = 0; k < 5; k++) begin
      if (k == 3) begin
        ev(6'h21, '0, 1'b0, va, sp);
        chk(32'(ex), 32'h1);
        lk(va, 1'b1, pa);
        lk(vc, 1'b0, pc);
        vb = va;
        pb = pa;
        fl(vc, pc, 1'b1);
      end
      // Last one carries intercept in host mode, which must flush anyway
      ev(arch_evt_t'((6'h20 >> k) | 6'(k == 4)), '0, 1'b0, va, sp);
      chk(32'(ex), 32'h0);
      lk(vb, 1'b0, pb);
      lk(vc, 1'(k < 2), pc);
      fl(vb, pb, 1'b0);
      if (k >= 2) fl(vc, pc, 1'b1);
    end
    // System events flush across spaces; page invalidate by space
    for (int k = 0; k < 5; k++) begin
      rnd();
      rst();
      fl(vc, pc, 1'b1);
      enter(CMD_NONE, sp);
      fl(vb, pb, 1'b0);
      lk(vc, 1'b1, pc);
      ev('0, '0, 1'b1, vb, sp + 8'h01);
      lk(vb, 1'b1, pb);
      ev('0, sys_evt_t'(5'h10 >> k), 1'b0, vb, sp);
      lk(vb, 1'b0, pb);
      lk(vc, 1'b0, pc);
    end
    fl(vb, pb, 1'b0);
    fl(va, pa, 1'b1);
    ev('0, '0, 1'b1, va, sp);
    lk(va, 1'b0, pa);
    lk(vb, 1'b1, pb);
    // Hypervisor duties: flush after edits, fresh space, full flush before reuse
    rnd();
    rst();
    enter(CMD_NONE, sp);
    fl(va, pa, 1'b1);
    fl(vb, pb, 1'b0);
    ev(6'h21, '0, 1'b0, va, sp);
    chk(32'(ex), 32'h1);
    enter(CMD_SPACE, sp);
    lk(va, 1'b0, pa);
    lk(vb, 1'b0, pb);
    fl(vc, pc, 1'b0);
    ev(6'h21, '0, 1'b0, va, sp);
    enter(CMD_NONE, sp + 8'h01);
    lk(vc, 1'b0, pc);
    ev(6'h21, '0, 1'b0, va, sp);
    enter(CMD_ALL, sp);
    lk(vc, 1'b0, pc);
    rdchk(REG_STATUS, {8'h00, CMD_ALL, 6'h00, 1'b0, 1'b1, sp});
    rdchk(REG_FLUSH_COUNT, 32'h2);
    wrap_up();
  end
endmodule
